// File: hw/srr_defs.svh
// constants for the stop recovery and reset status block
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

// register byte addresses
`define SRR_ADDR_W            12
`define SRR_OFS_CAUSE         12'hFF0
`define SRR_OFS_CTRL          12'hFF4
`define SRR_OFS_WAKE_MASK     12'hFF8
`define SRR_OFS_STATE         12'hFFC

// cause register fields
`define SRR_BIT_POR           7
`define SRR_BIT_STOP          6
`define SRR_BIT_WDT           5
`define SRR_BIT_EXT           4
`define SRR_BIT_FLT           3
`define SRR_BIT_PINSEL        0
`define SRR_CAUSE_RESET       5'h10

// cause patterns, flags [7:3]
`define SRR_PAT_POR           5'h10
`define SRR_PAT_PIN           5'h02
`define SRR_PAT_WDT_RST       5'h06
`define SRR_PAT_DBG           5'h12
`define SRR_PAT_FAULT         5'h03
`define SRR_PAT_SMR_GPIO      5'h08
`define SRR_PAT_SMR_WDT       5'h0C

// unlock sequence values
`define SRR_UNLOCK_1          8'h14
`define SRR_UNLOCK_2          8'h92

// control register fields
`define SRR_BIT_WDT_STOP_EN   0

// reset vector locations
`define SRR_VECTOR_LO         16'h0002
`define SRR_VECTOR_HI         16'h0003

// timing
`define SRR_RECOVER_IPO_CYCLES 7'd66
`define SRR_HALT_EXIT_NS      5000
`define SRR_CLK_PERIOD_NS     4

// wake pin count
`define SRR_WAKE_PINS         8

`endif

// File: hw/srr_pkg.sv
// types of the stop recovery and reset status block
package srr_pkg;

  typedef enum logic [2:0] {
    SRR_RUN     = 3'b000,
    SRR_HALT    = 3'b001,
    SRR_STOP    = 3'b010,
    SRR_RECOVER = 3'b011
  } srr_state_t;

  typedef enum logic [1:0] {
    SRR_LOCKED   = 2'b00,
    SRR_GOT_1    = 2'b01,
    SRR_UNLOCKED = 2'b10
  } srr_unlock_t;

endpackage

// File: hw/srr_wake_if.sv
// wake pin signals between the controller and its edge detector
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.svh"

interface srr_wake_if;
  logic [`SRR_WAKE_PINS-1:0] pins;
  logic [`SRR_WAKE_PINS-1:0] mask;
  logic                      wake;

  modport det (input pins, input mask, output wake);
  modport ctl (output pins, output mask, input wake);
endinterface

`default_nettype wire

// File: hw/srr_wake_det.sv
// gpio level change detector for stop-mode wake
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.svh"

module srr_wake_det
  import srr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  srr_wake_if.det   wk
);

  logic [`SRR_WAKE_PINS-1:0] prev;

  // remember last pin levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= '0;
    end else begin
      prev <= wk.pins;
    end
  end

  // pulse on either direction of change on an enabled pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wk.wake <= 1'b0;
    end else begin
      wk.wake <= |((wk.pins ^ prev) & wk.mask);
    end
  end

endmodule

`default_nettype wire

// File: hw/srr_ctrl.sv
// stop recovery, halt control and reset cause register
// Operation
// - recovery holds core and peripherals in reset for 66 oscillator cycles
// - recovery changes only cause and oscillator state, nothing else
// - after recovery the cpu loads pc from vector at 0002h and 0003h
// - watchdog timeout while stopped starts recovery, sets watchdog and stop flags
// - exception-mode watchdog: finish recovery, then deliver watchdog exception
// - level change on enabled gpio wakes from stop, sets stop flag only
// - reset pin selectable as pwm fault zero input, disabling its reset
// - pin select written only after 14h then 92h writes
// - software pin select write overrides the option bit value
// - pin select 0 is reset, 1 is fault; bit 0, loaded from option bit after reset
// - all cause flags updated together on each event, read-only
// - power-on sets only power flag; pin reset sets only pin flag
// - watchdog reset sets watchdog and pin; debugger sets power and pin
// - fault reset sets fault and pin flags, clears others
// - gpio recovery sets stop; watchdog recovery sets stop and watchdog
// - simultaneous causes may leave extra flags set
// - stop halts oscillators, clock, cpu, pc and idles peripherals
// - in stop watchdog and brown-out run only if enabled
// - halt stops cpu and pc; clock, watchdog and peripherals run
// - halt exits on interrupt, watchdog, power-on, brown-out or pin reset
// - execution resumes less than 5 us after halt exit event
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.svh"

module srr_ctrl
  import srr_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [`SRR_ADDR_W-1:0]    i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  input  wire logic                      i_por_event,
  input  wire logic                      i_bor_event,
  input  wire logic                      i_reset_pin_n,
  input  wire logic                      i_wdt_timeout,
  input  wire logic                      i_wdt_reset_mode,
  input  wire logic                      i_dbg_reset,
  input  wire logic                      i_fault_reset,
  input  wire logic                      i_stop_instr,
  input  wire logic                      i_halt_instr,
  input  wire logic                      i_irq,
  input  wire logic                      i_ipo_tick,
  input  wire logic                      i_pinsel_option,
  input  wire logic                      i_vbo_ao_option,
  input  wire logic [`SRR_WAKE_PINS-1:0] i_gpio,
  output logic                           o_sys_reset,
  output logic                           o_recover_hold,
  output logic                           o_cpu_run,
  output logic                           o_sys_clk_en,
  output logic                           o_osc_en,
  output logic                           o_periph_idle,
  output logic                           o_wdt_run,
  output logic                           o_vbo_run,
  output logic                           o_pwm_fault_input_zero,
  output logic                           o_fetch_vector,
  output logic      [15:0]               o_vector_addr,
  output logic                           o_wdt_exception
);

  srr_state_t                state;
  srr_state_t                next_state;
  srr_unlock_t               unlock;
  logic [4:0]                cause;
  logic                      pinsel;
  logic                      opt_loaded;
  logic                      wdt_stop_en;
  logic [`SRR_WAKE_PINS-1:0] wake_mask;
  logic [6:0]                rec_cnt;
  logic                      exc_pend;
  logic                      acc;
  logic                      wr_done;
  logic [31:0]               rd_val;
  logic                      pin_rst;
  logic                      wdt_rst;
  logic                      dbg_rst;
  logic                      any_rst;
  logic                      smr_wdt;
  logic                      smr_start;
  logic                      rec_done;
  logic                      halt_exit;
  logic [4:0]                rst_pat;

  srr_wake_if wk ();

  // feed pins and mask to the detector
  assign wk.pins = i_gpio;
  assign wk.mask = wake_mask;

  srr_wake_det u_wake (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wk      (wk)
  );

  // bus handshake terms
  assign acc     = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  assign wr_done = i_avs_write && !o_avs_waitrequest;

  // reset pin acts as reset only while selected as reset input
  assign pin_rst = !i_reset_pin_n && !pinsel;

  // watchdog and debugger resets are not system resets in stop
  assign wdt_rst = i_wdt_timeout && i_wdt_reset_mode
                   && (state != SRR_STOP) && (state != SRR_RECOVER);
  assign dbg_rst = i_dbg_reset && (state != SRR_STOP);
  assign any_rst = i_por_event || i_bor_event || pin_rst || wdt_rst
                   || dbg_rst || i_fault_reset;

  // stop-mode recovery starts
  assign smr_wdt   = (state == SRR_STOP) && i_wdt_timeout;
  assign smr_start = (state == SRR_STOP) && (smr_wdt || wk.wake);

  // recovery ends on the last oscillator cycle of the hold
  assign rec_done = (state == SRR_RECOVER) && i_ipo_tick
                    && (rec_cnt == (`SRR_RECOVER_IPO_CYCLES - 7'd1));

  // halt leaves on any wake cause, next cycle
  assign halt_exit = i_irq || i_wdt_timeout || i_por_event || i_bor_event
                     || !i_reset_pin_n;

  // cause patterns of all concurrent resets merged
  always_comb begin
    rst_pat = 5'h00;
    if (i_por_event || i_bor_event) begin
      rst_pat = rst_pat | `SRR_PAT_POR;
    end
    if (pin_rst) begin
      rst_pat = rst_pat | `SRR_PAT_PIN;
    end
    if (wdt_rst) begin
      rst_pat = rst_pat | `SRR_PAT_WDT_RST;
    end
    if (dbg_rst) begin
      rst_pat = rst_pat | `SRR_PAT_DBG;
    end
    if (i_fault_reset) begin
      rst_pat = rst_pat | `SRR_PAT_FAULT;
    end
  end

  // operating mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      SRR_RUN: begin
        if (i_stop_instr) begin
          next_state = SRR_STOP;
        end else if (i_halt_instr) begin
          next_state = SRR_HALT;
        end
      end
      SRR_HALT: begin
        if (halt_exit) begin
          next_state = SRR_RUN;
        end
      end
      SRR_STOP: begin
        if (smr_start) begin
          next_state = SRR_RECOVER;
        end
      end
      SRR_RECOVER: begin
        if (rec_done) begin
          next_state = SRR_RUN;
        end
      end
      default: begin
        next_state = SRR_RUN;
      end
    endcase
    if (any_rst) begin
      next_state = SRR_RUN;
    end
  end

  // mode register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SRR_RUN;
    end else begin
      state <= next_state;
    end
  end

  // recovery hold counter in oscillator cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec_cnt <= 7'd0;
    end else if (state != SRR_RECOVER) begin
      rec_cnt <= 7'd0;
    end else if (i_ipo_tick) begin
      rec_cnt <= rec_cnt + 7'd1;
    end
  end

  // watchdog exception waits until recovery ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exc_pend <= 1'b0;
    end else if (any_rst) begin
      exc_pend <= 1'b0;
    end else if (smr_start) begin
      exc_pend <= smr_wdt && !i_wdt_reset_mode;
    end else if (o_fetch_vector) begin
      exc_pend <= 1'b0; // kept through the fetch so the exception can follow it
    end
  end

  // exception and vector fetch after the hold
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch_vector  <= 1'b0;
      o_wdt_exception <= 1'b0;
      o_vector_addr   <= `SRR_VECTOR_LO;
    end else begin
      o_fetch_vector  <= rec_done && !any_rst;
      o_wdt_exception <= o_fetch_vector && exc_pend;
      o_vector_addr   <= `SRR_VECTOR_LO;
    end
  end

  // cause flags, all written together per event
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause <= `SRR_CAUSE_RESET;
    end else if (any_rst) begin
      cause <= rst_pat;
    end else if (smr_start) begin
      cause <= smr_wdt ? `SRR_PAT_SMR_WDT : `SRR_PAT_SMR_GPIO;
    end
  end

  // unlock tracker on cause register writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlock <= SRR_LOCKED;
    end else if (wr_done && (i_avs_address == `SRR_OFS_CAUSE)) begin
      if (unlock == SRR_UNLOCKED) begin
        unlock <= SRR_LOCKED;
      end else if (i_avs_writedata[7:0] == `SRR_UNLOCK_1) begin
        unlock <= SRR_GOT_1;
      end else if ((unlock == SRR_GOT_1)
                   && (i_avs_writedata[7:0] == `SRR_UNLOCK_2)) begin
        unlock <= SRR_UNLOCKED;
      end else begin
        unlock <= SRR_LOCKED;
      end
    end
  end

  // pin function select: option load after reset, then software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pinsel     <= 1'b0;
      opt_loaded <= 1'b0;
    end else if (!opt_loaded) begin
      pinsel     <= i_pinsel_option;
      opt_loaded <= 1'b1;
    end else if (wr_done && (i_avs_address == `SRR_OFS_CAUSE)
                 && (unlock == SRR_UNLOCKED)) begin
      pinsel <= i_avs_writedata[`SRR_BIT_PINSEL];
    end
  end

  // software control and wake mask, untouched by recovery
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_stop_en <= 1'b0;
      wake_mask   <= '0;
    end else if (wr_done) begin
      if (i_avs_address == `SRR_OFS_CTRL) begin
        wdt_stop_en <= i_avs_writedata[`SRR_BIT_WDT_STOP_EN];
      end
      if (i_avs_address == `SRR_OFS_WAKE_MASK) begin
        wake_mask <= i_avs_writedata[`SRR_WAKE_PINS-1:0];
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    case (i_avs_address)
      `SRR_OFS_CAUSE: begin
        rd_val[`SRR_BIT_POR:`SRR_BIT_FLT] = cause;
        rd_val[`SRR_BIT_PINSEL]           = pinsel;
      end
      `SRR_OFS_CTRL: begin
        rd_val[`SRR_BIT_WDT_STOP_EN] = wdt_stop_en;
      end
      `SRR_OFS_WAKE_MASK: begin
        rd_val[`SRR_WAKE_PINS-1:0] = wake_mask;
      end
      `SRR_OFS_STATE: begin
        rd_val[2:0] = state;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // avalon slave: one wait cycle, then answer for one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else if (acc) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata    <= i_avs_read ? rd_val : 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // system reset request and fault input
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_reset <= 1'b0;
      o_pwm_fault_input_zero    <= 1'b0;
    end else begin
      o_sys_reset <= any_rst;
      o_pwm_fault_input_zero    <= pinsel && !i_reset_pin_n;
    end
  end

  // clock, cpu and peripheral controls from the coming mode
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_recover_hold <= 1'b0;
      o_cpu_run      <= 1'b1;
      o_sys_clk_en   <= 1'b1;
      o_osc_en       <= 1'b1;
      o_periph_idle  <= 1'b0;
      o_wdt_run      <= 1'b1;
      o_vbo_run      <= 1'b1;
    end else begin
      // recovery hold keeps the register file, unlike system reset
      o_recover_hold <= (next_state == SRR_RECOVER);
      o_cpu_run      <= (next_state == SRR_RUN);
      o_sys_clk_en   <= (next_state != SRR_STOP);
      o_osc_en       <= (next_state != SRR_STOP);
      o_periph_idle  <= (next_state == SRR_STOP)
                        || (next_state == SRR_RECOVER);
      o_wdt_run      <= (next_state != SRR_STOP) || wdt_stop_en;
      o_vbo_run      <= (next_state != SRR_STOP) || i_vbo_ao_option;
    end
  end

endmodule

`default_nettype wire

// File: sim/srr_core_model.sv
// core side model: internal oscillator ticks and the vector load into the program counter
`timescale 1ns/1ps
`default_nettype none

module srr_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_osc_en,
  input  wire logic        i_fetch,
  input  wire logic [15:0] i_addr,
  output logic             o_tick,
  output logic      [15:0] o_pc
);
  logic [1:0] div;

  // program memory around the vector, other places read a filler byte
  function automatic logic [7:0] rom(input logic [15:0] a);
    return (a == 16'h0002) ? 8'h34 : ((a == 16'h0003) ? 8'h12 : 8'hA5);
  endfunction

  // oscillator stands still while disabled, one tick every third cycle otherwise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div    <= 2'h0;
      o_tick <= 1'b0;
    end else begin
      div    <= (i_osc_en && div != 2'h2) ? div + 2'h1 : 2'h0;
      o_tick <= i_osc_en && div == 2'h2;
    end
  end

  // pc takes low byte from the fetched place and high byte from the next one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_pc <= 16'h0000;
    else if (i_fetch) o_pc <= {rom(i_addr + 16'h0001), rom(i_addr)};
  end
endmodule

`default_nettype wire

// File: sim/srr_ctrl_asserts.sv
// concurrent checks on the ports of the stop recovery controller
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.svh"

module srr_ctrl_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_por_event,
  input wire logic        i_bor_event,
  input wire logic        i_reset_pin_n,
  input wire logic        i_wdt_timeout,
  input wire logic        i_dbg_reset,
  input wire logic        i_fault_reset,
  input wire logic        i_stop_instr,
  input wire logic        i_halt_instr,
  input wire logic        i_irq,
  input wire logic        i_ipo_tick,
  input wire logic        o_sys_reset,
  input wire logic        o_recover_hold,
  input wire logic        o_cpu_run,
  input wire logic        o_sys_clk_en,
  input wire logic        o_osc_en,
  input wire logic        o_periph_idle,
  input wire logic        o_pwm_fault_input_zero,
  input wire logic        o_fetch_vector,
  input wire logic [15:0] o_vector_addr,
  input wire logic        o_wdt_exception
);
  logic [6:0] ticks;
  logic       other_q;
  wire        src = i_por_event | i_bor_event | i_dbg_reset | i_fault_reset | i_wdt_timeout;
  wire        quiet = !src && i_reset_pin_n;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // oscillator ticks seen while the hold stands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ticks <= 7'd0;
    else if (!o_recover_hold) ticks <= 7'd0;
    else if (i_ipo_tick) ticks <= ticks + 7'd1;
  end

  // reset sources other than the pin, one cycle late
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) other_q <= 1'b0;
    else other_q <= src;
  end

  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  sequence s_fetch;
    o_fetch_vector && o_vector_addr == `SRR_VECTOR_LO;
  endsequence

  chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> s_answer)
    else $error("bus answer not after one wait cycle");
  chk_stop_entry: assert property (i_stop_instr && o_cpu_run && !o_sys_reset && quiet
    |=> !o_osc_en && !o_sys_clk_en && o_periph_idle && !o_cpu_run)
    else $error("stop did not halt clocks and core");
  chk_halt_entry: assert property (i_halt_instr && !i_stop_instr && o_cpu_run && !o_sys_reset
    && quiet |=> !o_cpu_run && o_sys_clk_en && o_osc_en && !o_periph_idle)
    else $error("halt state outputs wrong");
  chk_halt_exit: assert property (!o_cpu_run && !o_periph_idle && !o_sys_reset && i_irq
    |-> ##[1:2] o_cpu_run)
    else $error("halt not left in time");
  chk_recover_len: assert property ($fell(o_recover_hold) && !o_sys_reset
    |-> ticks == `SRR_RECOVER_IPO_CYCLES)
    else $error("recovery hold length wrong");
  chk_vector_fetch: assert property ($fell(o_recover_hold) && !o_sys_reset |-> s_fetch)
    else $error("no vector fetch after recovery");
  chk_exc_order: assert property (o_wdt_exception |-> $past(o_fetch_vector))
    else $error("watchdog exception not after fetch");
  chk_fault_source: assert property (o_pwm_fault_input_zero |-> $past(i_reset_pin_n) == 1'b0)
    else $error("pwm_fault_input_zero without pin low");
  chk_fault_no_reset: assert property (o_pwm_fault_input_zero && !other_q |-> !o_sys_reset)
    else $error("reset from pin in fault mode");
endmodule

bind srr_ctrl srr_ctrl_asserts srr_ctrl_asserts_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_por_event(i_por_event), .i_bor_event(i_bor_event),
  .i_reset_pin_n(i_reset_pin_n), .i_wdt_timeout(i_wdt_timeout), .i_dbg_reset(i_dbg_reset),
  .i_fault_reset(i_fault_reset), .i_stop_instr(i_stop_instr), .i_halt_instr(i_halt_instr),
  .i_irq(i_irq), .i_ipo_tick(i_ipo_tick), .o_sys_reset(o_sys_reset),
  .o_recover_hold(o_recover_hold), .o_cpu_run(o_cpu_run), .o_sys_clk_en(o_sys_clk_en),
  .o_osc_en(o_osc_en), .o_periph_idle(o_periph_idle), .o_pwm_fault_input_zero(o_pwm_fault_input_zero),
  .o_fetch_vector(o_fetch_vector), .o_vector_addr(o_vector_addr),
  .o_wdt_exception(o_wdt_exception));

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the stop recovery and reset status block
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s: expected %0h seen %0h", n, e, s); end end

module tb_top;
  import srr_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, pin_n = 1, wmode = 1, irq = 0;
  logic        popt = 0, vopt = 0, tick, exc_seen = 0;
  logic        avs_wait, sys_rst, hold, cpu_run, clk_en, osc_en, idle, wdt_run, vbo_run;
  logic        pwm_fault_input_zero, fetch, exc;
  logic [6:0]  ev = 0;
  logic [7:0]  gpio = 0, mask, ticks = 0;
  logic [11:0] addr = 0;
  logic [15:0] vaddr, pc;
  logic [31:0] wdata = 0, rdata, avs_rdata;
  int          bad_count = 0, comparisons = 0, cyc = 0, n;
  localparam int P_WDT = 1, P_STP = 4, P_HLT = 5, P_BOR = 6;

  srr_ctrl srr_ctrl_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_por_event(ev[0]), .i_bor_event(ev[P_BOR]), .i_reset_pin_n(pin_n), .i_wdt_timeout(ev[1]),
    .i_wdt_reset_mode(wmode), .i_dbg_reset(ev[2]), .i_fault_reset(ev[3]),
    .i_stop_instr(ev[4]), .i_halt_instr(ev[5]), .i_irq(irq), .i_ipo_tick(tick),
    .i_pinsel_option(popt), .i_vbo_ao_option(vopt), .i_gpio(gpio), .o_sys_reset(sys_rst),
    .o_recover_hold(hold), .o_cpu_run(cpu_run), .o_sys_clk_en(clk_en), .o_osc_en(osc_en),
    .o_periph_idle(idle), .o_wdt_run(wdt_run), .o_vbo_run(vbo_run), .o_pwm_fault_input_zero(pwm_fault_input_zero),
    .o_fetch_vector(fetch), .o_vector_addr(vaddr), .o_wdt_exception(exc));
  srr_core_model srr_core_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_osc_en(osc_en),
    .i_fetch(fetch), .i_addr(vaddr), .o_tick(tick), .o_pc(pc));

  always #2 clk = ~clk;

  // recovery ticks, late exceptions and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (hold === 1'b1 && tick === 1'b1) ticks = ticks + 8'd1;
    if (exc === 1'b1) exc_seen = 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [4:0] exp_cause(input int k);
    case (k)
      0: return `SRR_PAT_POR;
      1: return `SRR_PAT_WDT_RST;
      2: return `SRR_PAT_DBG;
      3: return `SRR_PAT_FAULT;
      4: return `SRR_PAT_SMR_GPIO;
      default: return `SRR_PAT_SMR_WDT;
    endcase
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    while (avs_wait !== 1'b0) @(posedge clk);
    rdata = avs_rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sel(input logic [7:0] v);
    bus(1'b1, `SRR_OFS_CAUSE, {24'h0, `SRR_UNLOCK_1});
    bus(1'b1, `SRR_OFS_CAUSE, {24'h0, `SRR_UNLOCK_2});
    bus(1'b1, `SRR_OFS_CAUSE, {24'h0, v});
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'h8421487C));
    gpio <= 8'($urandom);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
    `CHK("cause at start", {24'h0, `SRR_PAT_POR, 3'h0}, rdata)
    sel(8'hF9);
    bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
    `CHK("pin select set", {24'h0, `SRR_PAT_POR, 3'h1}, rdata)
    // a stray value between the unlock steps relocks
    bus(1'b1, `SRR_OFS_CAUSE, {24'h0, `SRR_UNLOCK_1});
    bus(1'b1, `SRR_OFS_CAUSE, 32'h40 | ($urandom & 32'h3F));
    bus(1'b1, `SRR_OFS_CAUSE, {24'h0, `SRR_UNLOCK_2});
    bus(1'b1, `SRR_OFS_CAUSE, 32'h0);
    bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
    `CHK("pin select kept", 1'b1, rdata[0])
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("pwm_fault_input_zero", 2'b10, {pwm_fault_input_zero, sys_rst})
    pin_n <= 1'b1;
    @(posedge clk);
    sel(8'h00);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
    `CHK("pin reset cause", {`SRR_PAT_PIN, 3'h0}, rdata[7:0])
    // last pass is a brown-out, which reports like a power-on
    for (int k = 0; k < 5; k++) begin
      pulse(k == 4 ? P_BOR : k);
      repeat (4) @(posedge clk);
      bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
      `CHK("reset cause", exp_cause(k == 4 ? 0 : k), rdata[7:3])
    end
    // stop, then wake by gpio, exception watchdog, reset watchdog
    for (int j = 0; j < 3; j++) begin
      mask = 8'($urandom_range(255, 1));
      bus(1'b1, `SRR_OFS_WAKE_MASK, {24'h0, mask});
      bus(1'b1, `SRR_OFS_CTRL, {31'h0, j != 0});
      wmode <= (j == 2);
      vopt  <= 1'($urandom);
      ticks = 8'd0;
      exc_seen = 1'b0;
      pulse(P_STP);
      repeat (2) @(posedge clk);
      `CHK("stop outputs", 4'b0001, {osc_en, clk_en, cpu_run, idle})
      `CHK("stop keepers", {j != 0, vopt}, {wdt_run, vbo_run})
      gpio <= gpio ^ ~mask;
      repeat (10) @(posedge clk);
      `CHK("unmasked pin wake", 1'b0, hold)
      if (j == 0) gpio <= gpio ^ (mask & (~mask + 8'h01));
      else pulse(P_WDT);
      while (hold !== 1'b1) @(posedge clk);
      while (hold !== 1'b0) @(posedge clk);
      while (fetch !== 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      `CHK("recovery ticks", 8'(`SRR_RECOVER_IPO_CYCLES), ticks)
      `CHK("vector load", 16'h1234, pc)
      `CHK("watchdog exception", j == 1, exc_seen)
      bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
      `CHK("recovery cause", exp_cause(j == 0 ? 4 : 5), rdata[7:3])
      bus(1'b0, `SRR_OFS_WAKE_MASK, 32'h0);
      `CHK("mask kept", {24'h0, mask}, rdata)
    end
    // halt, left by interrupt and by watchdog
    for (int h = 0; h < 2; h++) begin
      wmode <= 1'b0;
      pulse(P_HLT);
      repeat (2) @(posedge clk);
      `CHK("halt outputs", 4'b1100, {osc_en, clk_en, cpu_run, idle})
      if (h == 0) irq <= 1'b1;
      else pulse(P_WDT);
      n = 0;
      while (cpu_run !== 1'b1 && n < 50) begin
        @(posedge clk);
        n++;
      end
      irq <= 1'b0;
      `CHK("halt exit", 1'b1, cpu_run === 1'b1 && (n * `SRR_CLK_PERIOD_NS) < `SRR_HALT_EXIT_NS)
      repeat (3) @(posedge clk);
    end
    // reset again mid-run with the option bit set
    popt  <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, `SRR_OFS_CAUSE, 32'h0);
    `CHK("option load", {24'h0, `SRR_PAT_POR, 3'h1}, rdata)
    finish_test();
  end
endmodule

`default_nettype wire
